/* dv/tcoc_pin_model.sv */
// Port pin model in front of the two compare outputs
`timescale 1ns/100ps
module tcoc_pin_model (
   input wire logic clk,
   input wire logic [1:0] owns,
   input wire logic [1:0] wave,
   input wire logic [1:0] dir_out,
   input wire logic [1:0] port_val,
   output logic [1:0] pin
);
   logic [1:0] value;
   logic [1:0] last_reg = 2'h0;

   // ==========================================================
   // Pin mux and output driver
   // Compare unit takes the pin from the port while it owns it
   assign value = (owns & wave) | (~owns & port_val);

   always_ff @(posedge clk)
   begin
      last_reg <= (dir_out & value) | (~dir_out & last_reg);
   end

   // Released pin floats, shown as the inverse of its last level
   assign pin = (dir_out & value) | (~dir_out & ~last_reg);
endmodule : tcoc_pin_model

/* dv/testbench.sv */
// Self-checking testbench for the timer output control block
`timescale 1ns/100ps
module testbench;
   import tcoc_pkg::*;
   logic clk;
   logic reset_n;
   logic wr_en;
   logic rd_en;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic out_a;
   logic out_b;
   logic own_a;
   logic own_b;
   logic irq;
   logic [1:0] dir;
   logic [1:0] port;
   logic [1:0] pin;
   int fails = 0;
   int tests_run = 0;

   tcoc_timer_out tcoc_timer_out_i (.clk(clk), .reset_n(reset_n), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .compare_out_a(out_a),
      .compare_out_b(out_b), .chan_a_owns_pin(own_a), .chan_b_owns_pin(own_b), .irq(irq));

   tcoc_pin_model tcoc_pin_model_i (.clk(clk), .owns({own_b, own_a}), .wave({out_b, out_a}),
      .dir_out(dir), .port_val(port), .pin(pin));

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ==========================================================
   // Register access and checking
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      @(negedge clk);
   endtask : wr

   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      @(negedge clk);
      chk($sformatf("reg_%h", a), {8'h00, e}, {8'h00, rdata});
   endtask : rc

   // Configure from a stopped, zeroed counter, settle, then count high cycles and edges
   task automatic wave(input logic [7:0] om, cm, cmp, input bit ch, input int win, ex);
      int hi;
      int ed;
      logic prev;
      hi = 0;
      ed = 0;
      wr(8'h81, 8'h00);
      wr(8'h80, 8'h00);
      wr(8'h84, 8'h00);
      wr(8'h85, 8'h00);
      wr(8'h88, cmp);
      wr(8'h89, 8'h00);
      wr(8'h8a, cmp);
      wr(8'h8b, 8'h00);
      wr(8'h80, om);
      wr(8'h81, cm);
      repeat (600) @(negedge clk);
      prev = ch ? out_b : out_a;
      repeat (win)
      begin
         @(negedge clk);
         if ((ch ? out_b : out_a) === 1'b1)
            hi++;
         if ((ch ? out_b : out_a) !== prev)
            ed++;
         prev = ch ? out_b : out_a;
      end
      if (ex < 0)
         chk("wave_edges", 16'h0000, ed[15:0]);
      else
         chk("wave_high", ex[15:0], hi[15:0]);
   endtask : wave

   task automatic give_verdict();
      if (fails == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : give_verdict

   // ==========================================================
   // Watchdog
   initial
   begin
      repeat (60000) @(posedge clk);
      fails++;
      give_verdict();
   end

   // ==========================================================
   // Test sequence
   initial
   begin
      reset_n = 1'b0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      dir = 2'h0;
      port = 2'h0;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      rc(8'h80, 8'h00);
      rc(8'h81, 8'h00);
      chk("owns_a", 16'h0000, {15'h0, own_a});
      wr(8'h80, 8'hff);
      wr(8'h81, 8'hff);
      rc(8'h80, 8'hf3);
      rc(8'h81, 8'h1f);
      rc(8'h7f, 8'h00);
      chk("owns_a", 16'h0001, {15'h0, own_a});
      wr(8'h80, 8'h10);
      chk("owns_a", 16'h0000, {15'h0, own_a});
      chk("owns_b", 16'h0001, {15'h0, own_b});
      @(posedge clk);
      dir <= 2'h3;
      port <= 2'h1;
      @(negedge clk);
      chk("pin_a", 16'h0001, {15'h0, pin[0]});
      chk("pin_b", {15'h0, out_b}, {15'h0, pin[1]});
      wave(8'hc0, 8'h09, 8'h10, 0, 34, 34);
      wave(8'h80, 8'h09, 8'h10, 0, 34, 0);
      wave(8'h40, 8'h09, 8'h10, 0, 34, 17);
      wave(8'h81, 8'h09, 8'h40, 0, 256, 65);
      wave(8'hc1, 8'h09, 8'h40, 0, 256, 191);
      wave(8'h21, 8'h09, 8'h40, 1, 256, 65);
      wave(8'h81, 8'h09, 8'hff, 0, 256, 256);
      wave(8'h41, 8'h09, 8'h40, 0, 256, -1);
      wave(8'h43, 8'h19, 8'h10, 0, 34, 17);
      wave(8'h13, 8'h19, 8'h10, 1, 34, -1);
      wave(8'h81, 8'h01, 8'h80, 0, 510, 256);
      wave(8'hc1, 8'h01, 8'h80, 0, 510, 254);
      wave(8'h41, 8'h01, 8'h80, 0, 510, -1);
      wave(8'h43, 8'h11, 8'h10, 0, 64, 32);
      wave(8'h41, 8'h11, 8'h10, 0, 64, 32);
      wave(8'h40, 8'h0a, 8'h10, 0, 272, 136);
      wr(8'h81, 8'h00);
      wr(8'h90, 8'h07);
      wr(8'h91, 8'h00);
      rc(8'h90, 8'h00);
      wr(8'h81, 8'h09);
      repeat (40) @(negedge clk);
      wr(8'h81, 8'h00);
      rc(8'h90, 8'h03);
      chk("irq", 16'h0000, {15'h0, irq});
      wr(8'h91, 8'h01);
      chk("irq", 16'h0001, {15'h0, irq});
      wr(8'h90, 8'h01);
      chk("irq", 16'h0000, {15'h0, irq});
      rc(8'h90, 8'h02);
      give_verdict();
   end
endmodule : testbench

/* logic/tcoc_prescaler.sv */
// Prescaler producing the one-cycle timer tick enable
`timescale 1ns/100ps
`include "tcoc_defs.svh"
module tcoc_prescaler
   import tcoc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [2:0] clk_select,
   output logic timer_tick_enable
);
   logic [9:0] div_reg;
   logic [9:0] limit;
   logic tick_reg;

   always_comb
   begin
      unique case (clk_select)
         3'h2: limit = `TCOC_DIV_8;
         3'h3: limit = `TCOC_DIV_64;
         3'h4: limit = `TCOC_DIV_256;
         3'h5: limit = `TCOC_DIV_1024;
         default: limit = `TCOC_DIV_ZERO;
      endcase
   end

   // Divider counts I/O clocks; tick is an enable, not a clock
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         div_reg <= `TCOC_DIV_ZERO;
      else if (clk_select == 3'h0 || div_reg >= limit)
         div_reg <= `TCOC_DIV_ZERO;
      else
         div_reg <= div_reg + `TCOC_DIV_ONE;
   end

   // External clock selections are not supported here and stop the tick
   always_comb
   begin
      tick_reg = (clk_select != 3'h0) && (clk_select < 3'h6) && (div_reg >= limit);
   end
   assign timer_tick_enable = tick_reg;
endmodule : tcoc_prescaler

/* logic/tcoc_timer_out.sv */
// Timer counter with compare output and waveform mode control
// Behaviour
// - Timer tick is a clock enable only
// - Dual-slope frequency-correct loads compares at bottom
// - Nonzero mode field gives pin to compare
// - Code meaning depends on waveform kind
// - Non-PWM: off, toggle, clear, set on match
// - Fast PWM 01 toggles A in 14/15
// - Fast PWM 10/11 non-inverting or inverting
// - Fast PWM compare at top ignored, bottom acts
// - Dual-slope 01 toggles A in 9/11
// - Dual-slope 10/11 act by count direction
// - Mode code joins two registers' bits
// - Mode selects sequence, top, waveform
// - Normal, clear-on-match and three PWM kinds
// - Output mode register resets to zero
// - Upper mode bits in second register 4:3
// - Match sets the channel compare flag
`timescale 1ns/100ps
`include "tcoc_defs.svh"
module tcoc_timer_out
   import tcoc_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rdata,
   output logic compare_out_a,
   output logic compare_out_b,
   output logic chan_a_owns_pin,
   output logic chan_b_owns_pin,
   output logic irq
);
   // ==========================================================
   // Reset release
   logic rst_meta_reg;
   logic rst_n;
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   // ==========================================================
   // Registers
   logic [7:0] timer_output_mode_control_reg;
   logic [7:0] timer_clock_mode_control_reg;
   logic [15:0] compare_buf_a_reg, compare_buf_b_reg, capture_reg;
   logic [15:0] compare_value_reg_a, compare_value_reg_b;
   logic [15:0] count_value_reg;
   logic count_down_reg;
   logic [`TCOC_IRQ_WIDTH-1:0] irq_status_reg, irq_mask_reg, irq_event;
   logic [1:0] chan_a_out_mode, chan_b_out_mode;
   logic [3:0] wave_gen_mode;
   logic timer_tick_enable;
   logic cnt_write;

   assign chan_a_out_mode = timer_output_mode_control_reg[`TCOC_CHAN_A_HI:`TCOC_CHAN_A_LO];
   assign chan_b_out_mode = timer_output_mode_control_reg[`TCOC_CHAN_B_HI:`TCOC_CHAN_B_LO];
   assign wave_gen_mode = {timer_clock_mode_control_reg[`TCOC_WGM_UP_HI:`TCOC_WGM_UP_LO],
      timer_output_mode_control_reg[`TCOC_WGM_LOW_HI:`TCOC_WGM_LOW_LO]};

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         timer_output_mode_control_reg <= `TCOC_RST_BYTE;
         timer_clock_mode_control_reg <= `TCOC_RST_BYTE;
      end
      else if (wr_en && addr == `TCOC_OFS_OUT_MODE)
         timer_output_mode_control_reg <= wdata & `TCOC_OUT_MODE_MASK;
      else if (wr_en && addr == `TCOC_OFS_CLK_MODE)
         timer_clock_mode_control_reg <= wdata & `TCOC_CLK_MODE_MASK;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         compare_buf_a_reg <= `TCOC_RST_WORD;
         compare_buf_b_reg <= `TCOC_RST_WORD;
         capture_reg <= `TCOC_RST_WORD;
      end
      else if (wr_en)
      begin
         unique case (addr)
            `TCOC_OFS_COMPARE_A_LO: compare_buf_a_reg[7:0] <= wdata;
            `TCOC_OFS_COMPARE_A_HI: compare_buf_a_reg[15:8] <= wdata;
            `TCOC_OFS_COMPARE_B_LO: compare_buf_b_reg[7:0] <= wdata;
            `TCOC_OFS_COMPARE_B_HI: compare_buf_b_reg[15:8] <= wdata;
            `TCOC_OFS_CAPTURE_LO: capture_reg[7:0] <= wdata;
            `TCOC_OFS_CAPTURE_HI: capture_reg[15:8] <= wdata;
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Mode decode
   tcoc_kind_e kind;
   logic [15:0] top_value;
   logic double_buf, load_at_bottom, ovf_at_top, ovf_at_bottom;
   always_comb
   begin
      kind = TCOC_KIND_PLAIN;
      top_value = `TCOC_TOP_MAX;
      double_buf = 1'b1;
      load_at_bottom = 1'b0;
      ovf_at_top = 1'b0;
      ovf_at_bottom = 1'b1;
      unique case (wave_gen_mode)
         `TCOC_WGM_NORMAL, `TCOC_WGM_CTC_A, `TCOC_WGM_CTC_ICR:
         begin
            double_buf = 1'b0;
            ovf_at_bottom = 1'b0;
         end
         `TCOC_WGM_PC8, `TCOC_WGM_FAST8: top_value = `TCOC_TOP_8;
         `TCOC_WGM_PC9, `TCOC_WGM_FAST9: top_value = `TCOC_TOP_9;
         `TCOC_WGM_PC10, `TCOC_WGM_FAST10: top_value = `TCOC_TOP_10;
         `TCOC_WGM_PFC_ICR, `TCOC_WGM_PC_ICR, `TCOC_WGM_FAST_ICR: top_value = capture_reg;
         `TCOC_WGM_PFC_A, `TCOC_WGM_PC_A, `TCOC_WGM_FAST_A: top_value = compare_value_reg_a;
         default: ;
      endcase
      if (wave_gen_mode == `TCOC_WGM_CTC_A)
         top_value = compare_value_reg_a;
      if (wave_gen_mode == `TCOC_WGM_CTC_ICR)
         top_value = capture_reg;
      if (wave_gen_mode inside {`TCOC_WGM_FAST8, `TCOC_WGM_FAST9, `TCOC_WGM_FAST10,
         `TCOC_WGM_FAST_ICR, `TCOC_WGM_FAST_A})
      begin
         kind = TCOC_KIND_FAST;
         load_at_bottom = 1'b1;
         ovf_at_top = 1'b1;
         ovf_at_bottom = 1'b0;
      end
      else if (double_buf && wave_gen_mode != 4'hd)
         kind = TCOC_KIND_DUAL;
      if (wave_gen_mode inside {`TCOC_WGM_PFC_ICR, `TCOC_WGM_PFC_A})
         load_at_bottom = 1'b1;
   end

   // ==========================================================
   // Counter
   tcoc_prescaler u_prescaler (
      .clk(clk),
      .rst_n(rst_n),
      .clk_select(timer_clock_mode_control_reg[`TCOC_CS_HI:`TCOC_CS_LO]),
      .timer_tick_enable(timer_tick_enable)
   );

   logic at_top, at_bottom;
   assign at_top = count_value_reg == top_value;
   assign at_bottom = count_value_reg == `TCOC_BOTTOM;
   assign cnt_write = wr_en && (addr == `TCOC_OFS_COUNT_LO || addr == `TCOC_OFS_COUNT_HI);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_value_reg <= `TCOC_RST_WORD;
         count_down_reg <= 1'b0;
      end
      else if (cnt_write)
      begin
         if (addr == `TCOC_OFS_COUNT_LO)
            count_value_reg[7:0] <= wdata;
         else
            count_value_reg[15:8] <= wdata;
      end
      else if (timer_tick_enable)
      begin
         if (kind == TCOC_KIND_DUAL)
         begin
            if (at_top)
               count_down_reg <= 1'b1;
            else if (at_bottom)
               count_down_reg <= 1'b0;
            if (at_top || (count_down_reg && !at_bottom))
               count_value_reg <= count_value_reg - `TCOC_COUNT_ONE;
            else
               count_value_reg <= count_value_reg + `TCOC_COUNT_ONE;
         end
         else
         begin
            count_down_reg <= 1'b0;
            count_value_reg <= (at_top && wave_gen_mode != `TCOC_WGM_NORMAL) ? `TCOC_BOTTOM
               : count_value_reg + `TCOC_COUNT_ONE;
         end
      end
   end

   // Active compare registers: immediate, at top, or at bottom
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         compare_value_reg_a <= `TCOC_RST_WORD;
         compare_value_reg_b <= `TCOC_RST_WORD;
      end
      else if (!double_buf || (timer_tick_enable &&
         (load_at_bottom ? at_bottom : at_top)))
      begin
         compare_value_reg_a <= compare_buf_a_reg;
         compare_value_reg_b <= compare_buf_b_reg;
      end
   end

   // ==========================================================
   // Compare output units
   logic [1:0] match, out_reg, owns;
   logic [1:0][1:0] com;
   logic [1:0][15:0] cmp;
   tcoc_act_e [1:0] act;
   assign com[0] = chan_a_out_mode;
   assign com[1] = chan_b_out_mode;
   assign cmp[0] = compare_value_reg_a;
   assign cmp[1] = compare_value_reg_b;

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++)
      begin : g_chan
         assign match[ch] = timer_tick_enable && count_value_reg == cmp[ch];
         assign owns[ch] = com[ch] != `TCOC_COM_OFF;
         always_comb
         begin
            act[ch] = TCOC_ACT_NONE;
            unique case (kind)
               TCOC_KIND_PLAIN:
                  if (match[ch])
                     act[ch] = tcoc_act_e'(com[ch]);
               TCOC_KIND_FAST:
                  if (com[ch] == `TCOC_COM_TOGGLE)
                  begin
                     if (ch == 0 && match[ch] && wave_gen_mode[3:1] == 3'h7)
                        act[ch] = TCOC_ACT_TOGGLE;
                  end
                  else if (com[ch][1])
                  begin
                     if (match[ch] && !(cmp[ch] == top_value))
                        act[ch] = com[ch][0] ? TCOC_ACT_SET : TCOC_ACT_CLEAR;
                     else if (timer_tick_enable && at_top)
                        act[ch] = com[ch][0] ? TCOC_ACT_CLEAR : TCOC_ACT_SET;
                  end
               TCOC_KIND_DUAL:
                  if (com[ch] == `TCOC_COM_TOGGLE)
                  begin
                     if (ch == 0 && match[ch] && (wave_gen_mode == `TCOC_WGM_PFC_A ||
                        wave_gen_mode == `TCOC_WGM_PC_A))
                        act[ch] = TCOC_ACT_TOGGLE;
                  end
                  else if (com[ch][1] && match[ch])
                     act[ch] = (com[ch][0] ^ count_down_reg) ? TCOC_ACT_SET
                        : TCOC_ACT_CLEAR;
               default: ;
            endcase
         end
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               out_reg[ch] <= 1'b0;
            else
            begin
               unique case (act[ch])
                  TCOC_ACT_TOGGLE: out_reg[ch] <= !out_reg[ch];
                  TCOC_ACT_CLEAR: out_reg[ch] <= 1'b0;
                  TCOC_ACT_SET: out_reg[ch] <= 1'b1;
                  TCOC_ACT_NONE: ;
               endcase
            end
         end
      end
   endgenerate

   // Pin only drives when the port direction bit outside also selects output
   assign compare_out_a = out_reg[0];
   assign compare_out_b = out_reg[1];
   assign chan_a_owns_pin = owns[0];
   assign chan_b_owns_pin = owns[1];

   // ==========================================================
   // Interrupts
   assign irq_event[`TCOC_IRQ_MATCH_A] = match[0];
   assign irq_event[`TCOC_IRQ_MATCH_B] = match[1];
   assign irq_event[`TCOC_IRQ_OVERFLOW] = timer_tick_enable &&
      ((ovf_at_top && at_top) || (ovf_at_bottom && at_bottom && count_down_reg) ||
      (!ovf_at_top && !ovf_at_bottom && count_value_reg == `TCOC_TOP_MAX));
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_status_reg <= '0;
         irq_mask_reg <= '0;
      end
      else
      begin
         if (wr_en && addr == `TCOC_OFS_IRQ_MASK)
            irq_mask_reg <= wdata[`TCOC_IRQ_WIDTH-1:0];
         // Set wins over a simultaneous clear
         irq_status_reg <= (irq_status_reg & ~((wr_en && addr == `TCOC_OFS_IRQ_STATUS) ?
            wdata[`TCOC_IRQ_WIDTH-1:0] : '0)) | irq_event;
      end
   end
   assign irq = |(irq_status_reg & irq_mask_reg);

   // ==========================================================
   // Read port
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata <= `TCOC_RST_BYTE;
      else if (rd_en)
      begin
         unique case (addr)
            `TCOC_OFS_OUT_MODE: rdata <= timer_output_mode_control_reg;
            `TCOC_OFS_CLK_MODE: rdata <= timer_clock_mode_control_reg;
            `TCOC_OFS_COMPARE_A_LO: rdata <= compare_buf_a_reg[7:0];
            `TCOC_OFS_COMPARE_A_HI: rdata <= compare_buf_a_reg[15:8];
            `TCOC_OFS_COMPARE_B_LO: rdata <= compare_buf_b_reg[7:0];
            `TCOC_OFS_COMPARE_B_HI: rdata <= compare_buf_b_reg[15:8];
            `TCOC_OFS_CAPTURE_LO: rdata <= capture_reg[7:0];
            `TCOC_OFS_CAPTURE_HI: rdata <= capture_reg[15:8];
            `TCOC_OFS_COUNT_LO: rdata <= count_value_reg[7:0];
            `TCOC_OFS_COUNT_HI: rdata <= count_value_reg[15:8];
            `TCOC_OFS_IRQ_STATUS: rdata <= {5'h00, irq_status_reg};
            `TCOC_OFS_IRQ_MASK: rdata <= {5'h00, irq_mask_reg};
            default: rdata <= `TCOC_RST_BYTE;
         endcase
      end
      else
         rdata <= `TCOC_RST_BYTE;
   end

   // ==========================================================
   // Checks
   sequence tick_at_cmp_a_s;
      timer_tick_enable && count_value_reg == compare_value_reg_a;
   endsequence
   reg_reset_a: assert property (@(posedge clk) $rose(rst_n) |->
      timer_output_mode_control_reg == `TCOC_RST_BYTE) else $error("mode reg not zero");
   flag_set_a: assert property (@(posedge clk) disable iff (!rst_n) tick_at_cmp_a_s |=>
      irq_status_reg[`TCOC_IRQ_MATCH_A]) else $error("match flag missed");
   owns_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
      chan_b_owns_pin == (chan_b_out_mode != 2'h0)) else $error("pin ownership wrong");
   plain_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      (kind == TCOC_KIND_PLAIN && chan_a_out_mode == 2'h2) and tick_at_cmp_a_s
      |=> !compare_out_a)
      else $error("clear on match failed");
   fast_tog_a: assert property (@(posedge clk) disable iff (!rst_n)
      kind == TCOC_KIND_FAST && chan_b_out_mode == 2'h1 |=> $stable(compare_out_b))
      else $error("fast toggle B moved");
   dual_up_a: assert property (@(posedge clk) disable iff (!rst_n)
      (kind == TCOC_KIND_DUAL && chan_a_out_mode == 2'h2 && !count_down_reg) and
      tick_at_cmp_a_s |=> !compare_out_a) else $error("dual slope up clear failed");
   pfc_load_a: assert property (@(posedge clk) disable iff (!rst_n)
      load_at_bottom && timer_tick_enable && at_bottom |=> compare_value_reg_b == $past(compare_buf_b_reg))
      else $error("bottom load missed");
   tick_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
      timer_tick_enable && timer_clock_mode_control_reg[2:0] == 3'h2 |=> !timer_tick_enable)
      else $error("tick not single cycle");
endmodule : tcoc_timer_out

/* shared/tcoc_defs.svh */
// Register map, field positions, reset values and mode codes of the timer output control
`ifndef TCOC_DEFS_SVH
`define TCOC_DEFS_SVH
`define TCOC_OFS_OUT_MODE 8'h80
`define TCOC_OFS_CLK_MODE 8'h81
`define TCOC_OFS_COMPARE_A_LO 8'h88
`define TCOC_OFS_COMPARE_A_HI 8'h89
`define TCOC_OFS_COMPARE_B_LO 8'h8a
`define TCOC_OFS_COMPARE_B_HI 8'h8b
`define TCOC_OFS_CAPTURE_LO 8'h86
`define TCOC_OFS_CAPTURE_HI 8'h87
`define TCOC_OFS_COUNT_LO 8'h84
`define TCOC_OFS_COUNT_HI 8'h85
`define TCOC_OFS_IRQ_STATUS 8'h90
`define TCOC_OFS_IRQ_MASK 8'h91
`define TCOC_RST_BYTE 8'h00
`define TCOC_RST_WORD 16'h0000
`define TCOC_OUT_MODE_MASK 8'hf3
`define TCOC_CLK_MODE_MASK 8'h1f
`define TCOC_CHAN_A_HI 7
`define TCOC_CHAN_A_LO 6
`define TCOC_CHAN_B_HI 5
`define TCOC_CHAN_B_LO 4
`define TCOC_WGM_LOW_HI 1
`define TCOC_WGM_LOW_LO 0
`define TCOC_WGM_UP_HI 4
`define TCOC_WGM_UP_LO 3
`define TCOC_CS_HI 2
`define TCOC_CS_LO 0
`define TCOC_IRQ_MATCH_A 0
`define TCOC_IRQ_MATCH_B 1
`define TCOC_IRQ_OVERFLOW 2
`define TCOC_IRQ_WIDTH 3
`define TCOC_COM_OFF 2'h0
`define TCOC_COM_TOGGLE 2'h1
`define TCOC_COM_CLEAR 2'h2
`define TCOC_COM_SET 2'h3
`define TCOC_WGM_NORMAL 4'h0
`define TCOC_WGM_PC8 4'h1
`define TCOC_WGM_PC9 4'h2
`define TCOC_WGM_PC10 4'h3
`define TCOC_WGM_CTC_A 4'h4
`define TCOC_WGM_FAST8 4'h5
`define TCOC_WGM_FAST9 4'h6
`define TCOC_WGM_FAST10 4'h7
`define TCOC_WGM_PFC_ICR 4'h8
`define TCOC_WGM_PFC_A 4'h9
`define TCOC_WGM_PC_ICR 4'ha
`define TCOC_WGM_PC_A 4'hb
`define TCOC_WGM_CTC_ICR 4'hc
`define TCOC_WGM_FAST_ICR 4'he
`define TCOC_WGM_FAST_A 4'hf
`define TCOC_TOP_8 16'h00ff
`define TCOC_TOP_9 16'h01ff
`define TCOC_TOP_10 16'h03ff
`define TCOC_TOP_MAX 16'hffff
`define TCOC_BOTTOM 16'h0000
`define TCOC_COUNT_ONE 16'h0001
`define TCOC_DIV_8 10'd7
`define TCOC_DIV_64 10'd63
`define TCOC_DIV_256 10'd255
`define TCOC_DIV_1024 10'd1023
`define TCOC_DIV_ZERO 10'd0
`define TCOC_DIV_ONE 10'd1
`endif

/* shared/tcoc_pkg.sv */
// Types shared by the timer output control design
package tcoc_pkg;
   typedef enum logic [1:0] {TCOC_KIND_PLAIN, TCOC_KIND_FAST, TCOC_KIND_DUAL} tcoc_kind_e;
   typedef enum logic [1:0] {TCOC_ACT_NONE, TCOC_ACT_TOGGLE, TCOC_ACT_CLEAR, TCOC_ACT_SET}
      tcoc_act_e;
endpackage : tcoc_pkg
